// >>> dv/dgc_checker.sv
// Port checks for the DMA global control block.
`timescale 1ns/1ps
module dgc_checker
    import dgc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Memory bus
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic mem_err,
    // Done lines and interrupts
    input wire logic [NUM_CH-1:0] periph_done,
    input wire logic soft_channel_done_irq,
    input wire logic dma_error_irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic cfg_en;
    logic cfg_wr;
    logic err_clr;
    logic wb_ack;
    // Decodes of the writes that matter here.
    assign cfg_wr = reg_wr && (reg_addr == REG_CFG);
    assign err_clr = reg_wr && (reg_addr == REG_ERR) && reg_wdata[0];
    assign wb_ack = mem_req && mem_ack && mem_we;
    // The global enable has no port, so a shadow copy is kept here.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_en <= 1'b0;
        end else if (cfg_wr) begin
            cfg_en <= reg_wdata[0];
        end
    end
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_req_holds: assert property (mem_req && !mem_ack && !mem_err |=>
        mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
        else $error("memory request changed before its answer");
    a_req_drops: assert property (mem_req && (mem_ack || mem_err)
        |=> !mem_req) else $error("memory request outlived its answer");
    a_err_raises: assert property (mem_req && mem_err
        |-> ##[1:2] dma_error_irq) else $error("bus error not flagged");
    a_err_sticky: assert property (dma_error_irq && !err_clr
        |=> dma_error_irq) else $error("error interrupt dropped by itself");
    a_err_clears: assert property (err_clr && !(mem_req && mem_err)
        |=> !dma_error_irq) else $error("error interrupt not cleared");
    a_err_reads: assert property (reg_rd && reg_addr == REG_ERR
        |=> reg_rdata == {31'h0, $past(dma_error_irq)})
        else $error("error status does not match pending error");
    a_base_aligned: assert property (reg_rd && reg_addr == REG_CTLBASE
        |=> reg_rdata[9:0] == 10'h000) else $error("base low bits not zero");
    a_idle_disabled: assert property (!cfg_en && !cfg_wr && !mem_req
        |=> !mem_req) else $error("memory access while disabled");
    a_soft_pulse: assert property (soft_channel_done_irq
        |=> !soft_channel_done_irq) else $error("done pulse too long");
    a_soft_after_wb: assert property (soft_channel_done_irq
        |-> $past(wb_ack) || $past(wb_ack, 2))
        else $error("done pulse without final write-back");
    a_periph_alone: assert property (periph_done != 4'h0
        |-> $onehot(periph_done) && !soft_channel_done_irq)
        else $error("peripheral done raised wrong lines");
endmodule : dgc_checker

// >>> dv/dgc_mem_model.sv
// Behavioural system memory answering the engine's word accesses.
`timescale 1ns/1ps
module dgc_mem_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Memory bus
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic mem_err,
    output logic [31:0] mem_rdata,
    // Bench controls
    input wire logic [3:0] wait_cycles,
    input wire logic err_on,
    input wire logic [31:0] err_addr
);
    logic [31:0] mem [0:511];
    logic [3:0] waited;
    logic [31:0] last_data;
    // Between answers the data lines flip, so stale data never looks valid.
    assign mem_rdata = mem_ack ? last_data : ~last_data;
    // One answer per access after the chosen wait; writes land with it.
    always @(posedge clock) begin
        if (!rst_n || !mem_req || mem_ack || mem_err) begin
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            waited <= 4'h0;
        end else if (waited != wait_cycles) begin
            waited <= waited + 4'h1;
        end else if (err_on && mem_addr == err_addr) begin
            mem_err <= 1'b1;
        end else begin
            mem_ack <= 1'b1;
            last_data <= mem[mem_addr[10:2]];
            if (mem_we) begin
                mem[mem_addr[10:2]] <= mem_wdata;
            end
        end
    end
endmodule : dgc_mem_model

// >>> dv/testbench.sv
// Self-checking bench for the DMA global control block.
`timescale 1ns/1ps
module testbench;
    import dgc_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata;
    logic mem_req, mem_we, mem_ack, mem_err, req_q;
    logic [NUM_CH-1:0] periph_req = 4'h0;
    logic [NUM_CH-1:0] periph_done;
    logic soft_channel_done_irq, dma_error_irq;
    logic [3:0] wait_cycles = 4'h0;
    logic err_on = 1'b0;
    logic [31:0] err_addr = 32'h0;
    int mismatches = 0;
    int samples_checked = 0;
    int soft_seen = 0;
    int done_seen = 0;
    int starts = 0;
    always #10 clock = ~clock;
    dgc_top dut (.clock(clock), .rst_n(rst_n), .ce(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata),
        .periph_req(periph_req), .periph_done(periph_done),
        .soft_channel_done_irq(soft_channel_done_irq),
        .dma_error_irq(dma_error_irq));
    dgc_mem_model mem_i (.clock(clock), .rst_n(rst_n), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata),
        .wait_cycles(wait_cycles), .err_on(err_on), .err_addr(err_addr));
    // Count done pulses and fresh memory requests.
    always @(posedge clock) begin
        if (soft_channel_done_irq === 1'b1) soft_seen++;
        if (periph_done[0] === 1'b1) done_seen++;
        if (mem_req === 1'b1 && req_q !== 1'b1) starts++;
        req_q = mem_req;
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask : rd
    function automatic logic [31:0] pat(input logic [31:0] s, input int i);
        return 32'hC0DE_0000 + s + 32'(4 * i);
    endfunction : pat
    // Primary structure of a channel at base 0x400, plus its source words.
    task set_chan(input int ch, input logic [31:0] s, d, input int n,
        input logic [2:0] mode);
        for (int i = 0; i < n; i++) mem_i.mem[s[10:2] + i] = pat(s, i);
        mem_i.mem[9'h100 + ch * 4] = s;
        mem_i.mem[9'h101 + ch * 4] = d;
        mem_i.mem[9'h102 + ch * 4] = {18'h0, n[9:0], 1'b0, mode};
    endtask : set_chan
    task copied(input logic [31:0] s, d, input int n);
        for (int i = 0; i < n; i++) check(mem_i.mem[d[10:2] + i], pat(s, i));
    endtask : copied
    // Waits, bounded, for a count of soft done, peripheral done or error.
    task automatic wait_for(input int sel, input int target);
        int got;
        got = 0;
        for (int n = 0; n < 3000 && got < target; n++) begin
            @(posedge clock);
            #1 got = sel == 0 ? soft_seen : sel == 1 ? done_seen
                : int'(dma_error_irq === 1'b1);
        end
        check(got, target);
    endtask : wait_for
    task automatic idle_check(input int n);
        int s;
        s = starts;
        repeat (n) @(posedge clock);
        check(starts, s);
    endtask : idle_check
    task summarize;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    // A hang is cut off well beyond the few hundred cycles needed.
    initial begin
        #400000;
        mismatches++;
        summarize();
    end
    // Main sequence of tests.
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rd(REG_CFG, 32'h0);
        rd(REG_ENASET, 32'h0);
        rd(REG_ATTR, 32'h0);
        rd(REG_ERR, 32'h0);
        rd(8'h20, 32'h0);
        $display("test reset_values done");
        wr(REG_CTLBASE, 32'h0000_07FF);
        rd(REG_CTLBASE, 32'h0000_0400);
        wr(REG_ENASET, 32'h3);
        wr(REG_ENACLR, 32'h1);
        rd(REG_ENACLR, 32'h2);
        wr(REG_ENACLR, 32'h2);
        rd(REG_STAT, 32'h0);
        $display("test table_base done");
        set_chan(3, 32'h100, 32'h200, 20, MODE_AUTO);
        wr(REG_ENASET, 32'h8);
        wr(REG_SWREQ, 32'h8);
        idle_check(30);
        wr(REG_CFG, 32'h1);
        rd(REG_CFG, 32'h1);
        wait_for(0, 1);
        copied(32'h100, 32'h200, 20);
        check(mem_i.mem[9'h10E][2:0], MODE_STOP);
        check(mem_i.mem[9'h10E][13:4], 32'h0);
        rd(REG_ENASET, 32'h0);
        $display("test auto_copy done");
        wait_cycles <= 4'h2;
        set_chan(3, 32'h100, 32'h300, 3, MODE_AUTO);
        wr(REG_SWREQ, 32'h7);
        rd(REG_SWREQ, 32'h0);
        wr(REG_SWREQ, 32'h8);
        idle_check(20);
        wr(REG_ENASET, 32'h8);
        wait_for(0, 2);
        copied(32'h100, 32'h300, 3);
        set_chan(3, 32'h100, 32'h300, 3, MODE_STOP);
        wr(REG_ENASET, 32'h8);
        wr(REG_SWREQ, 32'h8);
        repeat (40) @(posedge clock);
        rd(REG_ENASET, 32'h0);
        check(soft_seen, 2);
        $display("test soft_request done");
        set_chan(0, 32'h180, 32'h280, 2, MODE_BASIC);
        wr(REG_ATTR, 32'h1);
        wr(REG_ENASET, 32'h1);
        periph_req <= 4'h1;
        idle_check(20);
        wr(REG_ATTR, 32'h0);
        wait_for(1, 1);
        periph_req <= 4'h0;
        check(soft_seen, 2);
        copied(32'h180, 32'h280, 2);
        $display("test peripheral done");
        err_addr <= 32'h100;
        err_on <= 1'b1;
        set_chan(3, 32'h100, 32'h200, 2, MODE_AUTO);
        wr(REG_ENASET, 32'h8);
        wr(REG_SWREQ, 32'h8);
        wait_for(2, 1);
        rd(REG_ERR, 32'h1);
        idle_check(10);
        check(dma_error_irq, 1'b1);
        rd(REG_ENASET, 32'h0);
        check(soft_seen, 2);
        wr(REG_ERR, 32'h1);
        rd(REG_ERR, 32'h0);
        check(dma_error_irq, 1'b0);
        rd(REG_STAT, 32'hC);
        $display("test bus_error done");
        summarize();
    end
endmodule : testbench
// Attach the port checker to the top design module.
bind dgc_top dgc_checker chk (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_err(mem_err), .periph_done(periph_done),
    .soft_channel_done_irq(soft_channel_done_irq),
    .dma_error_irq(dma_error_irq));

// >>> rtl/dgc_fifo.sv
// Word FIFO that stages data between source reads and destination writes.
`timescale 1ns/1ps
module dgc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and control
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] fill;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    // Full and empty come from the pointer distance.
    assign fill = wr_ptr - rd_ptr;
    assign in_ready = (fill != DEPTH[AW:0]);
    assign out_valid = (fill != '0);
    assign out_data = mem[rd_ptr[AW-1:0]];

    // Storage is not reset; only the pointers decide what is valid.
    always_ff @(posedge clock) begin
        if (ce && push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // Pointers; a flush drops everything still held.
    always_ff @(posedge clock) begin
        if (!rst_n || (ce && flush)) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (ce) begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end
endmodule : dgc_fifo

// >>> rtl/dgc_pkg.sv
// Shared constants and types of the DMA global control block.
package dgc_pkg;
    // Channel set and data path.
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam logic [1:0] SW_CH = 2'h3;
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] BURST_MAX = 5'h10;

    // Control table layout.
    localparam int TABLE_BYTES = 1024;
    localparam int BASE_LSB = 10;
    localparam int STRUCT_SHIFT = 4;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [1:0] IDX_SRC = 2'h0;
    localparam logic [1:0] IDX_DST = 2'h1;
    localparam logic [1:0] IDX_CTL = 2'h2;

    // Control word fields.
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;
    localparam int CNT_LSB = 4;
    localparam int CNT_W = 10;
    localparam logic [2:0] MODE_STOP = 3'h0;
    localparam logic [2:0] MODE_BASIC = 3'h1;
    localparam logic [2:0] MODE_AUTO = 3'h2;

    // Register offsets.
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_CTLBASE = 8'h04;
    localparam logic [7:0] REG_ENASET = 8'h08;
    localparam logic [7:0] REG_ENACLR = 8'h0C;
    localparam logic [7:0] REG_SWREQ = 8'h10;
    localparam logic [7:0] REG_ATTR = 8'h14;
    localparam logic [7:0] REG_ERR = 8'h18;
    localparam logic [7:0] REG_STAT = 8'h1C;

    // Reset values.
    localparam logic [21:0] RST_CTLBASE = 22'h000000;
    localparam logic [3:0] RST_CH = 4'h0;

    // Engine states, Gray coded along the transfer path.
    typedef enum logic [2:0] {
        DGC_IDLE = 3'b000,
        DGC_FETCH = 3'b001,
        DGC_READ = 3'b011,
        DGC_WRITE = 3'b010,
        DGC_WBACK = 3'b110
    } dgc_state_e;
endpackage : dgc_pkg

// >>> rtl/dgc_req_sel.sv
// Request synchroniser and fixed-priority channel picker.
`timescale 1ns/1ps
module dgc_req_sel
    import dgc_pkg::*;
(
    // Clock and control
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Request sources
    input wire logic [NUM_CH-1:0] periph_req,
    input wire logic [NUM_CH-1:0] sw_pend,
    input wire logic [NUM_CH-1:0] ch_en,
    input wire logic [NUM_CH-1:0] attr_mask,
    // Choice
    output logic [NUM_CH-1:0] req_live,
    output logic pick_valid,
    output logic [CH_W-1:0] pick_ch
);
    logic [NUM_CH-1:0] req_meta;
    logic [NUM_CH-1:0] req_sync;
    logic [NUM_CH-1:0] cand;

    // Peripheral lines come from other logic; two flops before use.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            req_meta <= '0;
            req_sync <= '0;
        end else if (ce) begin
            req_meta <= periph_req;
            req_sync <= req_meta;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++) begin : g_cand
            if (i == int'(SW_CH)) begin : g_sw
                assign cand[i] = ch_en[i] & sw_pend[i];
                assign req_live[i] = sw_pend[i];
            end else begin : g_per
                assign cand[i] = ch_en[i] & req_sync[i] & ~attr_mask[i];
                assign req_live[i] = req_sync[i] & ~attr_mask[i];
            end
        end
    endgenerate

    // Lowest channel number wins; starvation is left to software.
    always_comb begin
        pick_ch = '0;
        for (int k = NUM_CH - 1; k >= 0; k--) begin
            if (cand[k]) begin
                pick_ch = CH_W'(k);
            end
        end
    end
    assign pick_valid = |cand;
endmodule : dgc_req_sel

// >>> rtl/dgc_top.sv
// DMA global control: registers, table-driven transfer engine, errors.
`timescale 1ns/1ps
module dgc_top
    import dgc_pkg::*;
(
    // Clock, reset and clock enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // System memory bus
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [31:0] mem_rdata,
    // Peripheral side
    input wire logic [NUM_CH-1:0] periph_req,
    output logic [NUM_CH-1:0] periph_done,
    // Controller interrupts
    output logic soft_channel_done_irq,
    output logic dma_error_irq
);
    // Software state.
    logic global_en;
    logic [31-BASE_LSB:0] ctl_base;
    logic [NUM_CH-1:0] ch_en;
    logic [NUM_CH-1:0] sw_pend;
    logic [NUM_CH-1:0] attr_mask;
    logic err_flag;

    // Engine state.
    dgc_state_e state;
    logic [CH_W-1:0] cur_ch;
    logic [1:0] idx;
    logic [31:0] src_ptr;
    logic [31:0] dst_ptr;
    logic [MODE_W-1:0] mode;
    logic [CNT_W-1:0] remaining;
    logic [4:0] burst_left;

    // Picker and FIFO links.
    logic [NUM_CH-1:0] req_live;
    logic pick_valid;
    logic [CH_W-1:0] pick_ch;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;

    // Register decode.
    wire wr_cfg = reg_wr & (reg_addr == REG_CFG);
    wire wr_base = reg_wr & (reg_addr == REG_CTLBASE);
    wire wr_eset = reg_wr & (reg_addr == REG_ENASET);
    wire wr_eclr = reg_wr & (reg_addr == REG_ENACLR);
    wire wr_swreq = reg_wr & (reg_addr == REG_SWREQ);
    wire wr_attr = reg_wr & (reg_addr == REG_ATTR);
    wire wr_err = reg_wr & (reg_addr == REG_ERR);
    wire [NUM_CH-1:0] wmask = reg_wdata[NUM_CH-1:0];

    // Memory handshake terms.
    wire acc_done = mem_req & (mem_ack | mem_err);
    wire acc_ok = mem_req & mem_ack & ~mem_err;
    wire bus_err = mem_req & mem_err;
    wire fetch_last = acc_ok & (state == DGC_FETCH) & (idx == IDX_CTL);
    wire wback_last = acc_ok & (state == DGC_WBACK) & (idx == IDX_CTL);

    // channel structures stay inside the table
    wire [31:0] struct_addr = {ctl_base, {BASE_LSB{1'b0}}}
        | (32'(cur_ch) << STRUCT_SHIFT);
    wire [31:0] idx_addr = struct_addr + {28'h0000000, idx, 2'b00};
    wire [CNT_W-1:0] fetched_cnt = mem_rdata[CNT_LSB +: CNT_W];
    wire [MODE_W-1:0] fetched_mode = mem_rdata[MODE_LSB +: MODE_W];
    wire [4:0] next_burst = (remaining > CNT_W'(BURST_MAX)) ?
        BURST_MAX : remaining[4:0];
    wire [4:0] fetch_burst = (fetched_cnt > CNT_W'(BURST_MAX)) ?
        BURST_MAX : fetched_cnt[4:0];
    wire fetch_stop = (fetched_mode == MODE_STOP) | (fetched_cnt == '0);
    wire xfer_done = (remaining == '0);
    // auto mode needs no further request
    wire keep_going = (mode == MODE_AUTO) | req_live[cur_ch];
    wire drained = ~fifo_out_valid & ~mem_req;

    // stopped mode written back at the end
    wire [MODE_W-1:0] wb_mode = xfer_done ? MODE_STOP : mode;
    wire [31:0] wb_ctl = (32'(remaining) << CNT_LSB)
        | (32'(wb_mode) << MODE_LSB);
    wire [31:0] wb_data = (idx == IDX_SRC) ? src_ptr :
        (idx == IDX_DST) ? dst_ptr : wb_ctl;

    // Next access the engine wants on the bus.
    wire want_acc = (state == DGC_FETCH) | (state == DGC_WBACK)
        | ((state == DGC_READ) & (burst_left != '0) & fifo_in_ready)
        | ((state == DGC_WRITE) & fifo_out_valid);
    wire acc_we = (state == DGC_WRITE) | (state == DGC_WBACK);
    wire [31:0] acc_addr = (state == DGC_READ) ? src_ptr :
        (state == DGC_WRITE) ? dst_ptr : idx_addr;
    wire [31:0] acc_wdata = (state == DGC_WRITE) ? fifo_out_data : wb_data;
    wire issue = want_acc & global_en & ~mem_req;

    // Completion and abort events.
    wire finish_ok = wback_last & xfer_done;
    wire finish_stop = fetch_last & fetch_stop;
    wire start = (state == DGC_IDLE) & pick_valid & global_en;
    wire [NUM_CH-1:0] cur_onehot = NUM_CH'(1) << cur_ch;
    wire [NUM_CH-1:0] pick_onehot = NUM_CH'(1) << pick_ch;
    wire [NUM_CH-1:0] hw_en_clr = (finish_ok | finish_stop | bus_err) ?
        cur_onehot : '0;
    wire [NUM_CH-1:0] sw_take = start ? (pick_onehot & sw_pend) : '0;

    // Register read mux, answered one cycle after the strobe.
    wire [31:0] rd_mux =
        (reg_addr == REG_CFG) ? {31'h0, global_en} :
        (reg_addr == REG_CTLBASE) ? {ctl_base, {BASE_LSB{1'b0}}} :
        (reg_addr == REG_ENASET) ? {28'h0, ch_en} :
        (reg_addr == REG_ENACLR) ? {28'h0, ch_en} :
        (reg_addr == REG_SWREQ) ? {28'h0, sw_pend} :
        (reg_addr == REG_ATTR) ? {28'h0, attr_mask} :
        (reg_addr == REG_ERR) ? {31'h0, err_flag} :
        (reg_addr == REG_STAT) ?
            {24'h0, 1'b0, state, cur_ch, 1'b0, mem_req} :
        32'h0000_0000;

    // Software registers; a hardware set beats a same-cycle clear.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            global_en <= 1'b0;
            ctl_base <= RST_CTLBASE;
            ch_en <= RST_CH;
            sw_pend <= RST_CH;
            attr_mask <= RST_CH;
            err_flag <= 1'b0;
            reg_rdata <= 32'h0000_0000;
        end else if (ce) begin
            if (wr_cfg) begin
                global_en <= reg_wdata[0];
            end
            if (wr_base) begin
                ctl_base <= reg_wdata[31:BASE_LSB];
            end
            ch_en <= (ch_en & ~hw_en_clr & ~(wr_eclr ? wmask : '0))
                | (wr_eset ? wmask : '0);
            sw_pend <= (sw_pend & ~sw_take)
                | (wr_swreq ? (wmask & NUM_CH'(cur_onehot_sw())) : '0);
            if (wr_attr) begin
                attr_mask <= wmask;
            end
            err_flag <= bus_err | (err_flag & ~(wr_err & reg_wdata[0]));
            reg_rdata <= reg_rd ? rd_mux : reg_rdata;
        end
    end

    // Only the software channel accepts software requests.
    function automatic logic [NUM_CH-1:0] cur_onehot_sw();
        cur_onehot_sw = NUM_CH'(1) << SW_CH;
    endfunction : cur_onehot_sw

    // Bus request stays up until the memory answers.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
        end else if (ce) begin
            if (issue) begin
                mem_req <= 1'b1;
                mem_we <= acc_we;
                mem_addr <= acc_addr;
                mem_wdata <= acc_wdata;
            end else if (acc_done) begin
                mem_req <= 1'b0;
            end
        end
    end

    // Transfer engine.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= DGC_IDLE;
            cur_ch <= '0;
            idx <= IDX_SRC;
            src_ptr <= 32'h0000_0000;
            dst_ptr <= 32'h0000_0000;
            mode <= MODE_STOP;
            remaining <= '0;
            burst_left <= '0;
        end else if (ce) begin
            if (bus_err) begin
                state <= DGC_IDLE;
            end else begin
                unique case (state)
                    DGC_IDLE: begin
                        if (start) begin
                            cur_ch <= pick_ch;
                            idx <= IDX_SRC;
                            state <= DGC_FETCH;
                        end
                    end
                    DGC_FETCH: begin
                        if (acc_ok) begin
                            idx <= idx + 2'h1;
                            if (idx == IDX_SRC) begin
                                src_ptr <= mem_rdata;
                            end
                            if (idx == IDX_DST) begin
                                dst_ptr <= mem_rdata;
                            end
                            if (idx == IDX_CTL) begin
                                mode <= fetched_mode;
                                remaining <= fetched_cnt;
                                burst_left <= fetch_burst;
                                state <= fetch_stop ? DGC_IDLE : DGC_READ;
                            end
                        end
                    end
                    DGC_READ: begin
                        if (acc_ok) begin
                            src_ptr <= src_ptr + WORD_STEP;
                            burst_left <= burst_left - 5'h01;
                        end
                        if (burst_left == '0 && !mem_req) begin
                            state <= DGC_WRITE;
                        end
                    end
                    DGC_WRITE: begin
                        if (acc_ok) begin
                            dst_ptr <= dst_ptr + WORD_STEP;
                            remaining <= remaining - CNT_W'(1);
                        end
                        if (drained) begin
                            idx <= IDX_SRC;
                            if (!xfer_done && keep_going) begin
                                burst_left <= next_burst;
                                state <= DGC_READ;
                            end else begin
                                state <= DGC_WBACK;
                            end
                        end
                    end
                    DGC_WBACK: begin
                        if (acc_ok) begin
                            idx <= idx + 2'h1;
                        end
                        if (wback_last) begin
                            state <= DGC_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Completion strobes, one cycle each.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            soft_channel_done_irq <= 1'b0;
            periph_done <= '0;
        end else if (ce) begin
            soft_channel_done_irq <= finish_ok & (cur_ch == SW_CH);
            periph_done <= (finish_ok && cur_ch != SW_CH) ? cur_onehot : '0;
        end
    end

    // error interrupt follows the pending flag
    assign dma_error_irq = err_flag;

    dgc_req_sel u_sel (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .periph_req(periph_req),
        .sw_pend(sw_pend),
        .ch_en(ch_en),
        .attr_mask(attr_mask),
        .req_live(req_live),
        .pick_valid(pick_valid),
        .pick_ch(pick_ch)
    );

    // Source words land here and drain to the destination.
    dgc_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .flush(bus_err),
        .in_valid(acc_ok & (state == DGC_READ)),
        .in_ready(fifo_in_ready),
        .in_data(mem_rdata),
        .out_valid(fifo_out_valid),
        .out_ready(acc_ok & (state == DGC_WRITE)),
        .out_data(fifo_out_data)
    );
endmodule : dgc_top
